// *** src/bmi_pkg.sv ***
// Constants shared by the battery monitor event interrupt block
package bmi_pkg;
    // Register indices (byte address is four times the index)
    localparam logic [7:0] IDX_INT_ENABLE = 8'h02;
    localparam logic [7:0] IDX_PIN1_CONFIG = 8'h0d;
    localparam logic [7:0] IDX_PIN2_CONFIG = 8'h0e;
    localparam logic [7:0] IDX_PIN3_CONFIG = 8'h0f;
    localparam logic [7:0] IDX_EVENT_FLAGS = 8'h27;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h31;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h32;

    // Enable register field positions
    localparam int EN_CHARGER = 11;
    localparam int EN_LOAD = 12;
    localparam int EN_CUR_RELEASE = 13;
    localparam int EN_CUR_HIGH = 14;
    localparam int EN_WDOG = 15;
    localparam int EN_LSB = 11;
    localparam int EN_W = 5;

    // Event flag field positions
    localparam int FLAG_CHG_FALL = 8;
    localparam int FLAG_CHG_RISE = 9;
    localparam int FLAG_LOAD_RELEASE = 10;
    localparam int FLAG_LOAD_ATTACH = 11;
    localparam int FLAG_CUR_HIGH = 12;
    localparam int FLAG_WDOG = 13;
    localparam int FLAG_CHG_LEVEL = 14;
    localparam int FLAG_LOAD_LEVEL = 15;
    localparam int FLAG_LSB = 8;
    localparam int FLAG_W = 6;

    // Output select field of each pin configuration register
    localparam int SEL_LSB = 8;
    localparam int SEL_W = 4;
    localparam logic [3:0] SEL_IRQ_OR = 4'hd;

    // Sticky status bits: six flag events plus current release
    localparam int STS_W = 7;
    localparam int STS_CUR_RELEASE = 6;

    // Reset values
    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam logic [6:0] RST_STS = 7'h00;

    // Release delay of the interrupt line
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int HOLD_TIME_NS = 12_000;
    localparam int HOLD_CYC = (HOLD_TIME_NS / 1000) * (CLK_FREQ_HZ / 1_000_000);
    localparam int HOLD_W = 11;
endpackage : bmi_pkg

// *** src/bmi_event_irq.sv ***
// Event interrupt logic with APB register file for the battery monitor
// How it works
// - Current drop below threshold pulses the line, no flag
// - Fast current above threshold interrupts, sets bit 12
// - Current interrupts only in auto detect mode
// - Write 1 clears current flag, line 12us later
// - Current release interrupt on the line self clears after 12us
// - Watchdog warning sets flag and asserts interrupt
// - Write 1 clears watchdog flag, line 12us later
// - Each pin has 4-bit select at 11:8
// - Bit 11 enables charger flags and interrupt
// - Bit 12 enables load flags and interrupt
// - Bit 13 enables current release interrupt
// - Bit 14 enables current high flag, interrupt
// - Bit 15 enables watchdog warning flag, interrupt
// - Bits 8/9 latch charger fall/rise, write-1 clear
// - Charger pin edges interrupt and set flags
// - Load edges with FETs off set bits 11/10
module bmi_event_irq #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External detect pins, asynchronous
    input wire logic charger_detect_pin,
    input wire logic load_detect_pin,
    // Internal status from neighbouring logic, same clock
    input wire logic fets_off,
    input wire logic active_mode,
    input wire logic auto_detect_mode,
    input wire logic current_below_threshold,
    input wire logic current_above_threshold,
    input wire logic watchdog_warning,
    // Pin interrupt outputs
    output logic [2:0] pin_int_n,
    output logic [2:0] pin_int_routed,
    output logic int_n,
    // Level interrupt to local software
    output logic irq
);

    // One struct holds every flop so reset and update stay together
    // Whole state of the block
    typedef struct packed {
        logic [1:0] chg_sync;   // Charger pin synchroniser
        logic [1:0] load_sync;  // Load pin synchroniser
        logic chg_prev;         // Charger level last cycle
        logic load_prev;        // Load level last cycle
        logic cur_low_prev;     // Threshold compare history
        logic cur_high_prev;
        logic [4:0] int_en;     // Enable bits 15:11
        logic [11:0] pin_sel;   // Three 4-bit selects
        logic [5:0] flags;      // Latched flags 13:8
        logic [6:0] irq_sts;    // Sticky status
        logic [6:0] irq_en;     // Status enable
        logic [10:0] hold_cnt;  // Line release delay
        logic int_n;            // Combined line, active low
        logic irq;              // Software interrupt level
        logic [31:0] prdata;    // Read data
    } bmi_state_s;

    bmi_state_s s;      // Current state
    bmi_state_s next_s; // Next state

    // Only aligned words match; byte lanes are not decoded
    // Register address match for one word
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        addr_hit = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction

    // Select field of one pin
    function automatic logic [3:0] pin_field(input logic [11:0] sel, input int n);
        pin_field = sel[n*bmi_pkg::SEL_W +: bmi_pkg::SEL_W];
    endfunction

    // Mapped address check
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = addr_hit(a, bmi_pkg::IDX_INT_ENABLE) || addr_hit(a, bmi_pkg::IDX_PIN1_CONFIG)
            || addr_hit(a, bmi_pkg::IDX_PIN2_CONFIG) || addr_hit(a, bmi_pkg::IDX_PIN3_CONFIG)
            || addr_hit(a, bmi_pkg::IDX_EVENT_FLAGS) || addr_hit(a, bmi_pkg::IDX_IRQ_STATUS)
            || addr_hit(a, bmi_pkg::IDX_IRQ_ENABLE) || addr_hit(a, bmi_pkg::IDX_IRQ_CLEAR);
    endfunction

    // Decoded enables
    logic en_chg;
    logic en_load;
    logic en_rel;
    logic en_high;
    logic en_wdt;
    // Mask of flags whose enable is on
    logic [5:0] flag_mask;
    // Synchronised pin levels
    logic chg_lvl;
    logic load_lvl;
    // Events, one cycle each except the watchdog warning level
    logic ev_chg_rise;
    logic ev_chg_fall;
    logic ev_load_attach;
    logic ev_load_release;
    logic ev_cur_rel;
    logic ev_cur_high;
    logic ev_wdt;
    logic [5:0] flag_set;
    logic [6:0] sts_set;
    // Bus strobes
    logic wr_en;
    logic rd_setup;
    logic [5:0] flag_clr;
    logic [6:0] sts_clr;
    logic cleared_any;
    logic pending;
    logic [15:0] flags_view;

    // Enables sit in bits 15:11 of the enable word
    // Enable decode
    always_comb
    begin
        en_chg = s.int_en[bmi_pkg::EN_CHARGER - bmi_pkg::EN_LSB];
        en_load = s.int_en[bmi_pkg::EN_LOAD - bmi_pkg::EN_LSB];
        en_rel = s.int_en[bmi_pkg::EN_CUR_RELEASE - bmi_pkg::EN_LSB];
        en_high = s.int_en[bmi_pkg::EN_CUR_HIGH - bmi_pkg::EN_LSB];
        en_wdt = s.int_en[bmi_pkg::EN_WDOG - bmi_pkg::EN_LSB];
        // Disabling a source also stops its pending flag driving the line
        flag_mask = {en_wdt, en_high, en_load, en_load, en_chg, en_chg};
    end

    // Event detection
    always_comb
    begin
        chg_lvl = s.chg_sync[1];
        load_lvl = s.load_sync[1];
        // Edges compare the synchronised level with last cycle
        // A pin held high across reset release gives one late edge
        // Charger edges, any mode but sleep and shutdown
        ev_chg_rise = en_chg && active_mode && chg_lvl && !s.chg_prev;
        ev_chg_fall = en_chg && active_mode && !chg_lvl && s.chg_prev;
        // Load edges only count with both power FETs off
        ev_load_attach = en_load && active_mode && fets_off && !load_lvl && s.load_prev;
        ev_load_release = en_load && active_mode && fets_off && load_lvl && !s.load_prev;
        // Current events need intermittent auto detection
        // Edge triggered, so a level that stays does not refire
        ev_cur_rel = en_rel && auto_detect_mode && current_below_threshold
            && !s.cur_low_prev;
        ev_cur_high = en_high && auto_detect_mode && current_above_threshold
            && !s.cur_high_prev;
        // Warning pulse arrives 100ms ahead of expiry
        // Every high cycle of the warning counts again
        ev_wdt = en_wdt && active_mode && watchdog_warning;
        flag_set = {ev_wdt, ev_cur_high, ev_load_attach, ev_load_release, ev_chg_rise, ev_chg_fall};
        sts_set = {ev_cur_rel, flag_set};
    end

    // Bus decode
    always_comb
    begin
        // Zero wait states, so every access phase completes
        // Reads load in setup so data is settled in access
        // Unmapped words answer with an error and change nothing
        wr_en = psel && penable && pwrite;
        rd_setup = psel && !penable && !pwrite;
        flag_clr = '0;
        sts_clr = '0;
        if (wr_en && addr_hit(paddr, bmi_pkg::IDX_EVENT_FLAGS))
        begin
            flag_clr = pwdata[bmi_pkg::FLAG_LSB +: bmi_pkg::FLAG_W];
        end
        if (wr_en && addr_hit(paddr, bmi_pkg::IDX_IRQ_CLEAR))
        begin
            sts_clr = pwdata[bmi_pkg::STS_W-1:0];
        end
        // A clear that meets a simultaneous set does not count
        cleared_any = |(s.flags & flag_clr & ~flag_set & flag_mask);
        pending = |(s.flags & flag_mask);
        // Flag register view with live pin levels on top
        flags_view = {load_lvl, chg_lvl, s.flags, 8'h00};
    end

    // Next state
    always_comb
    begin
        next_s = s;
        // Pin synchronisers, first stage read only by second
        next_s.chg_sync = {s.chg_sync[0], charger_detect_pin};
        next_s.load_sync = {s.load_sync[0], load_detect_pin};
        next_s.chg_prev = s.chg_sync[1];
        next_s.load_prev = s.load_sync[1];
        // Compare inputs share this clock, no synchroniser needed
        next_s.cur_low_prev = current_below_threshold;
        next_s.cur_high_prev = current_above_threshold;

        // Register writes
        // Only the defined fields are stored; the rest read zero
        if (wr_en && addr_hit(paddr, bmi_pkg::IDX_INT_ENABLE))
        begin
            next_s.int_en = pwdata[bmi_pkg::EN_LSB +: bmi_pkg::EN_W];
        end
        if (wr_en && addr_hit(paddr, bmi_pkg::IDX_PIN1_CONFIG))
        begin
            next_s.pin_sel[3:0] = pwdata[bmi_pkg::SEL_LSB +: bmi_pkg::SEL_W];
        end
        if (wr_en && addr_hit(paddr, bmi_pkg::IDX_PIN2_CONFIG))
        begin
            next_s.pin_sel[7:4] = pwdata[bmi_pkg::SEL_LSB +: bmi_pkg::SEL_W];
        end
        if (wr_en && addr_hit(paddr, bmi_pkg::IDX_PIN3_CONFIG))
        begin
            next_s.pin_sel[11:8] = pwdata[bmi_pkg::SEL_LSB +: bmi_pkg::SEL_W];
        end
        if (wr_en && addr_hit(paddr, bmi_pkg::IDX_IRQ_ENABLE))
        begin
            next_s.irq_en = pwdata[bmi_pkg::STS_W-1:0];
        end

        // Latched flags, set wins over clear
        // Status records every enabled event whatever the status enable
        next_s.flags = (s.flags & ~flag_clr) | flag_set;
        next_s.irq_sts = (s.irq_sts & ~sts_clr) | sts_set;

        // Release delay: restarted by a release event or a flag clear
        // Counted on this clock, so the delay scales with its frequency
        // A release event or flag clear during the delay restarts it, never shortens it
        if (ev_cur_rel || cleared_any)
        begin
            next_s.hold_cnt = bmi_pkg::HOLD_W'(bmi_pkg::HOLD_CYC);
        end
        else if (s.hold_cnt != '0)
        begin
            next_s.hold_cnt = s.hold_cnt - 1'b1;
        end

        // Line low while a flag pends or the delay runs
        // Registered so the pin never glitches between sources
        next_s.int_n = !(pending || (next_s.flags & flag_mask) != '0
            || next_s.hold_cnt != '0);
        next_s.irq = |(next_s.irq_sts & next_s.irq_en);

        // Read data captured in the setup phase
        // Data stands until the next read setup
        if (rd_setup)
        begin
            next_s.prdata = '0;
            case (1'b1)
                addr_hit(paddr, bmi_pkg::IDX_INT_ENABLE):
                begin
                    next_s.prdata[bmi_pkg::EN_LSB +: bmi_pkg::EN_W] = s.int_en;
                end
                addr_hit(paddr, bmi_pkg::IDX_PIN1_CONFIG):
                begin
                    next_s.prdata[bmi_pkg::SEL_LSB +: bmi_pkg::SEL_W] = pin_field(s.pin_sel, 0);
                end
                addr_hit(paddr, bmi_pkg::IDX_PIN2_CONFIG):
                begin
                    next_s.prdata[bmi_pkg::SEL_LSB +: bmi_pkg::SEL_W] = pin_field(s.pin_sel, 1);
                end
                addr_hit(paddr, bmi_pkg::IDX_PIN3_CONFIG):
                begin
                    next_s.prdata[bmi_pkg::SEL_LSB +: bmi_pkg::SEL_W] = pin_field(s.pin_sel, 2);
                end
                addr_hit(paddr, bmi_pkg::IDX_EVENT_FLAGS):
                begin
                    next_s.prdata[15:0] = flags_view;
                end
                addr_hit(paddr, bmi_pkg::IDX_IRQ_STATUS):
                begin
                    next_s.prdata[bmi_pkg::STS_W-1:0] = s.irq_sts;
                end
                addr_hit(paddr, bmi_pkg::IDX_IRQ_ENABLE):
                begin
                    next_s.prdata[bmi_pkg::STS_W-1:0] = s.irq_en;
                end
                default:
                begin
                    // Clear register and unmapped words read zero
                    next_s.prdata = '0;
                end
            endcase
        end
    end

    // State register
    // Asynchronous reset loads constants only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s.chg_sync <= 2'h0;
            s.load_sync <= 2'h0;
            s.chg_prev <= 1'b0;
            s.load_prev <= 1'b0;
            s.cur_low_prev <= 1'b0;
            s.cur_high_prev <= 1'b0;
            s.int_en <= bmi_pkg::RST_REG16[bmi_pkg::EN_LSB +: bmi_pkg::EN_W];
            s.pin_sel <= bmi_pkg::RST_REG16[11:0];
            s.flags <= bmi_pkg::RST_REG16[bmi_pkg::FLAG_LSB +: bmi_pkg::FLAG_W];
            s.irq_sts <= bmi_pkg::RST_STS;
            s.irq_en <= bmi_pkg::RST_STS;
            s.hold_cnt <= 11'h000;
            s.int_n <= 1'b1;
            s.irq <= 1'b0;
            s.prdata <= 32'h0000_0000;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Pin routing: only select code 1101 carries the line
    // Unrouted pins idle high so the receiver sees no edge
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            pin_int_routed[i] = (pin_field(s.pin_sel, i) == bmi_pkg::SEL_IRQ_OR);
            pin_int_n[i] = pin_int_routed[i] ? s.int_n : 1'b1;
        end
    end

    // Bus answers and outputs
    // No wait states, so ready is tied high
    always_comb
    begin
        pready = 1'b1;
        pslverr = psel && penable && !mapped(paddr);
        prdata = s.prdata;
        int_n = s.int_n;
        irq = s.irq;
    end

endmodule // bmi_event_irq

// *** dv/bmi_event_irq_chk.sv ***
// Port-level assertions for the event interrupt block
module bmi_event_irq_chk #(
    parameter int ADDR_W = 12
) (
    // Clock, reset and APB
    input wire logic pclk, presetn, psel, penable, pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic pready, pslverr,
    // Event inputs
    input wire logic charger_detect_pin, load_detect_pin, fets_off, active_mode,
    input wire logic auto_detect_mode, current_below_threshold, current_above_threshold, watchdog_warning,
    // Interrupt outputs
    input wire logic [2:0] pin_int_n, pin_int_routed,
    input wire logic int_n, irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] en_q; // Shadow of the enable register
    logic wr_done; // Completed write transfer
    assign wr_done = psel && penable && pwrite && pready;
    // Shadow kept from bus writes, since the checker cannot see inside
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_q <= 16'h0000;
        end
        else if (wr_done && paddr == ADDR_W'(12'h008))
        begin
            en_q <= pwdata[15:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Line falls a few cycles after a synchronised pin edge
    sequence s_low_soon;
        ##[1:6] !int_n;
    endsequence
    // Line stays low for the first eight cycles of the release delay
    sequence s_low_held;
        !int_n [*8];
    endsequence
    a_route_pins: assert property (pin_int_n == (~pin_int_routed | {3{int_n}}))
        else $error("pin output differs from routed line");
    a_reset_quiet: assert property ($rose(presetn) |-> int_n && !irq && pin_int_routed == 3'b000)
        else $error("outputs not idle after reset");
    a_cur_high: assert property ($rose(current_above_threshold) && auto_detect_mode && en_q[14] |=> !int_n)
        else $error("high current did not pull line");
    a_cur_release: assert property ($rose(current_below_threshold) && auto_detect_mode && en_q[13]
        |=> s_low_held)
        else $error("current release did not pull line");
    a_wdog_warn: assert property (watchdog_warning && active_mode && en_q[15] |=> s_low_held)
        else $error("watchdog warning did not pull line");
    a_clear_hold: assert property (wr_done && paddr == ADDR_W'(12'h09c) && pwdata[13:8] != 6'h00 && !int_n
        |=> s_low_held)
        else $error("line released too soon after clear");
    a_chg_edge: assert property ($changed(charger_detect_pin) && en_q[11] && active_mode |-> s_low_soon)
        else $error("charger edge did not pull line");
    a_load_edge: assert property ($changed(load_detect_pin) && en_q[12] && active_mode && fets_off
        |-> s_low_soon)
        else $error("load edge did not pull line");
endmodule // bmi_event_irq_chk

bind bmi_event_irq bmi_event_irq_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .charger_detect_pin(charger_detect_pin), .load_detect_pin(load_detect_pin),
    .fets_off(fets_off), .active_mode(active_mode), .auto_detect_mode(auto_detect_mode),
    .current_below_threshold(current_below_threshold), .current_above_threshold(current_above_threshold),
    .watchdog_warning(watchdog_warning), .pin_int_n(pin_int_n), .pin_int_routed(pin_int_routed),
    .int_n(int_n), .irq(irq));

// *** dv/bmi_mcu_model.sv ***
// Microcontroller model counting interrupts on its pin
module bmi_mcu_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Interrupt pin, active low
    input wire logic int_pin_n,
    // Interrupts seen
    output int n_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_q; // Previous pin level
    // Count each fall; the pin only moves once routed with the OR code
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_q <= 1'b1;
            n_irq <= 0;
        end
        else
        begin
            last_q <= int_pin_n;
            n_irq <= n_irq + ((last_q && !int_pin_n) ? 1 : 0);
        end
    end
endmodule // bmi_mcu_model

// *** dv/testbench.sv ***
// Self-checking bench for the battery monitor event interrupt block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, slverr, sv; // Bus
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic chg, ld, fets, act, auto, below, above, wdog, int_n, irq; // Events
    logic [2:0] pin_n, routed;
    int n_fail, checks_done, n_irq;
    bmi_event_irq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(slverr),
        .charger_detect_pin(chg), .load_detect_pin(ld), .fets_off(fets), .active_mode(act),
        .auto_detect_mode(auto), .current_below_threshold(below), .current_above_threshold(above),
        .watchdog_warning(wdog), .pin_int_n(pin_n), .pin_int_routed(routed), .int_n(int_n), .irq(irq));
    bmi_mcu_model mcu (.pclk(pclk), .presetn(presetn), .int_pin_n(pin_n[0]), .n_irq(n_irq));
    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Verdict and end of run
    task results;
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, request held until pready
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        sv = slverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Read and compare
    task rchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask
    // Line level away from the clock edge
    task line(input int n, input logic exp);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, int_n}, {31'h0, exp});
    endtask
    // Low through most of the release delay, high after it
    task hold;
        line(1090, 1'b0);
        line(150, 1'b1);
    endtask
    // Write one to clear, read back, watch the release
    task clr(input logic [31:0] m, input logic [31:0] left);
        apb(1'b1, bmi_pkg::IDX_EVENT_FLAGS, m);
        rchk(bmi_pkg::IDX_EVENT_FLAGS, left);
        hold;
    endtask
    // Main sequence
    initial
    begin
        {psel, penable, pwrite, chg, ld, auto, below, above, wdog} = '0;
        {act, fets} = 2'b11;
        paddr = 12'h000;
        pwdata = 32'h0;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rchk(bmi_pkg::IDX_INT_ENABLE, 32'h0);
        rchk(bmi_pkg::IDX_EVENT_FLAGS, 32'h0);
        apb(1'b0, 8'h50, 32'h0);
        chk(sv, 1'b1);
        for (int i = 0; i < 3; i++)
            apb(1'b1, bmi_pkg::IDX_PIN1_CONFIG + 8'(i), (i == 1) ? 32'h0c00 : 32'h0d00);
        rchk(bmi_pkg::IDX_PIN2_CONFIG, 32'h0c00);
        chk(routed, 3'b101);
        @(posedge pclk) chg <= 1'b1;
        line(8, 1'b1);
        rchk(bmi_pkg::IDX_EVENT_FLAGS, 32'h4000);
        apb(1'b1, bmi_pkg::IDX_INT_ENABLE, 32'hf800);
        @(posedge pclk) chg <= 1'b0;
        line(8, 1'b0);
        chk(pin_n, 3'b010);
        rchk(bmi_pkg::IDX_EVENT_FLAGS, 32'h0100);
        clr(32'h0100, 32'h0);
        @(posedge pclk) ld <= 1'b1;
        line(8, 1'b0);
        rchk(bmi_pkg::IDX_EVENT_FLAGS, 32'h8400);
        clr(32'h0400, 32'h8000);
        @(posedge pclk) ld <= 1'b0;
        line(8, 1'b0);
        clr(32'h0800, 32'h0);
        @(posedge pclk) above <= 1'b1;
        line(8, 1'b1);
        @(posedge pclk);
        above <= 1'b0;
        auto <= 1'b1;
        @(posedge pclk) above <= 1'b1;
        line(2, 1'b0);
        rchk(bmi_pkg::IDX_EVENT_FLAGS, 32'h1000);
        clr(32'h1000, 32'h0);
        @(posedge pclk) below <= 1'b1;
        line(2, 1'b0);
        rchk(bmi_pkg::IDX_EVENT_FLAGS, 32'h0);
        hold;
        @(posedge pclk) wdog <= 1'b1;
        @(posedge pclk) wdog <= 1'b0;
        rchk(bmi_pkg::IDX_EVENT_FLAGS, 32'h2000);
        clr(32'h2000, 32'h0);
        rchk(bmi_pkg::IDX_IRQ_STATUS, 32'h7d);
        apb(1'b1, bmi_pkg::IDX_IRQ_CLEAR, 32'h7f);
        apb(1'b1, bmi_pkg::IDX_IRQ_ENABLE, 32'h7f);
        @(posedge pclk) chg <= 1'b1;
        line(8, 1'b0);
        chk(irq, 1'b1);
        rchk(bmi_pkg::IDX_IRQ_STATUS, 32'h02);
        apb(1'b1, bmi_pkg::IDX_IRQ_ENABLE, 32'h0);
        line(2, 1'b0);
        chk(irq, 1'b0);
        apb(1'b1, bmi_pkg::IDX_IRQ_CLEAR, 32'h02);
        rchk(bmi_pkg::IDX_IRQ_STATUS, 32'h0);
        clr(32'h0200, 32'h4000);
        @(posedge pclk) {fets, ld} <= 2'b01;
        line(8, 1'b1);
        @(posedge pclk) ld <= 1'b0;
        line(8, 1'b1);
        @(posedge pclk) {act, chg} <= 2'b00;
        line(8, 1'b1);
        rchk(bmi_pkg::IDX_EVENT_FLAGS, 32'h0);
        chk(n_irq, 7);
        results;
    end
    // Hang guard, well past the expected run
    initial
    begin
        #200000;
        n_fail++;
        results;
    end
endmodule // testbench
